//--- hdl/dcw_config_decoder.sv
`include "dcw_defines.svh"
`default_nettype none
module dcw_config_decoder #(
  parameter bit          LARGE_PART           = 1'b1,
  parameter int unsigned POWER_UP_BASE_CYCLES = `DCW_POWER_UP_BASE_MS * (`DCW_CLK_HZ / 1000)
) (
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  prog_write_in,
  input  wire logic [23:0]           prog_addr_in,
  input  wire logic [23:0]           prog_data_in,
  input  wire logic                  chip_erase_in,
  input  wire logic                  table_read_in,
  input  wire logic [23:0]           table_addr_in,
  output logic [23:0]                table_data_out,
  output logic                       table_valid_out,
  input  wire logic                  reset_control_write_in,
  input  wire logic [15:0]           reset_control_wdata_in,
  output logic                       watchdog_software_enable_out,
  input  wire logic                  low_power_rc_tick_in,
  input  wire logic                  watchdog_clear_instruction_in,
  input  wire logic                  sleep_in,
  output logic                       boot_write_enable_out,
  output var dcw_pkg::dcw_security_t boot_security_out,
  output logic [23:0]                boot_segment_end_out,
  output logic                       general_write_enable_out,
  output var dcw_pkg::dcw_security_t general_security_out,
  output logic                       watchdog_enable_out,
  output logic                       low_power_rc_oscillator_run_out,
  output logic                       watchdog_window_mode_out,
  output logic [7:0]                 watchdog_prescale_out,
  output logic [15:0]                watchdog_postscale_out,
  output logic                       power_up_timer_enable_out,
  output logic [7:0]                 power_up_timer_ms_out,
  output logic [23:0]                power_up_timer_cycles_out,
  output logic                       watchdog_reset_out,
  output logic                       watchdog_wake_out
);
  localparam int WORDS = `DCW_WORD_COUNT;
  localparam logic [WORDS-1:0][23:0] WORD_ADDR = {
    `DCW_ADDR_POWER_ON, `DCW_ADDR_WATCHDOG, `DCW_ADDR_OSC,
    `DCW_ADDR_OSC_SEL, `DCW_ADDR_GENERAL, `DCW_ADDR_BOOT};
  localparam logic [WORDS-1:0][15:0] WORD_MASK = {
    `DCW_MASK_POWER_ON, `DCW_MASK_WATCHDOG, `DCW_MASK_OSC,
    `DCW_MASK_OSC_SEL, `DCW_MASK_GENERAL, `DCW_MASK_BOOT};
  localparam logic [23:0] POWER_UP_BASE = 24'(POWER_UP_BASE_CYCLES);

  logic [WORDS-1:0][15:0] cfg_reg;
  logic [WORDS-1:0][15:0] cfg_next;
  logic [WORDS-1:0]       write_hit;
  logic [WORDS-1:0]       read_hit;
  logic [23:0]            read_word;
  logic                   swen_reg;
  logic [2:0]             boot_size;
  logic [1:0]             general_prot;
  logic                   wd_config_enable;
  logic                   wd_enable;
  logic [3:0]             postscale_sel;
  logic [2:0]             power_up_code;

  // per-word decode, store and erase
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      assign write_hit[gi] = (prog_addr_in == WORD_ADDR[gi]);
      assign read_hit[gi]  = (table_addr_in == WORD_ADDR[gi]);
      // unassigned bits stored as one so they read back high
      assign cfg_next[gi]  = chip_erase_in ? `DCW_ERASED_WORD :
                             (prog_write_in && write_hit[gi])
                               ? (prog_data_in[15:0] | ~WORD_MASK[gi])
                               : cfg_reg[gi];
    end
  endgenerate

  // storage models the fuse latches; reset loads the erased state
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cfg_reg <= {WORDS{`DCW_ERASED_WORD}};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  always_comb begin
    read_word = `DCW_UNMAPPED_READ;
    for (int i = 0; i < WORDS; i++) begin
      if (read_hit[i]) begin
        read_word = {`DCW_UPPER_BYTE, cfg_reg[i]};
      end
    end
  end

  // table read answers one cycle later with the pre-write value
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      table_data_out  <= `DCW_UNMAPPED_READ;
      table_valid_out <= 1'b0;
    end else begin
      table_valid_out <= table_read_in;
      if (table_read_in) begin
        table_data_out <= read_word;
      end
    end
  end

  assign boot_size         = cfg_reg[0][`DCW_BOOT_SIZE_LSB +: 3];
  assign general_prot      = cfg_reg[1][`DCW_GEN_PROT_LSB +: 2];
  assign wd_config_enable  = cfg_reg[4][`DCW_WDTEN_BIT];
  assign postscale_sel     = cfg_reg[4][`DCW_POSTSCALE_LSB +: 4];
  assign power_up_code     = cfg_reg[5][`DCW_POWER_UP_LSB +: 3];
  assign wd_enable         = wd_config_enable | swen_reg;

  // software enable; clears ignored while config forces the watchdog
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      swen_reg <= 1'b0;
    end else if (reset_control_write_in) begin
      if (reset_control_wdata_in[`DCW_SOFT_EN_BIT] || !wd_config_enable) begin
        swen_reg <= reset_control_wdata_in[`DCW_SOFT_EN_BIT];
      end
    end
  end
  assign watchdog_software_enable_out = swen_reg;

  // boot segment
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      boot_write_enable_out <= 1'b1;
      boot_security_out     <= dcw_pkg::DCW_SEC_NONE;
      boot_segment_end_out  <= 24'h000000;
    end else begin
      boot_write_enable_out <= cfg_reg[0][`DCW_BOOT_WP_BIT];
      case (boot_size)
        3'b110: begin
          boot_security_out    <= dcw_pkg::DCW_SEC_STANDARD;
          boot_segment_end_out <= `DCW_BOOT_END_SMALL;
        end
        3'b010: begin
          boot_security_out    <= dcw_pkg::DCW_SEC_HIGH;
          boot_segment_end_out <= `DCW_BOOT_END_SMALL;
        end
        3'b101: begin
          // smaller parts have no medium segment
          boot_security_out    <= LARGE_PART ? dcw_pkg::DCW_SEC_STANDARD
                                             : dcw_pkg::DCW_SEC_NONE;
          boot_segment_end_out <= LARGE_PART ? `DCW_BOOT_END_MEDIUM : 24'h000000;
        end
        3'b001: begin
          boot_security_out    <= LARGE_PART ? dcw_pkg::DCW_SEC_HIGH
                                             : dcw_pkg::DCW_SEC_NONE;
          boot_segment_end_out <= LARGE_PART ? `DCW_BOOT_END_MEDIUM : 24'h000000;
        end
        default: begin
          boot_security_out    <= dcw_pkg::DCW_SEC_NONE;
          boot_segment_end_out <= 24'h000000;
        end
      endcase
    end
  end

  // general segment
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      general_write_enable_out <= 1'b1;
      general_security_out     <= dcw_pkg::DCW_SEC_NONE;
    end else begin
      general_write_enable_out <= cfg_reg[1][`DCW_GEN_WP_BIT];
      case (general_prot)
        2'b11:   general_security_out <= dcw_pkg::DCW_SEC_NONE;
        2'b10:   general_security_out <= dcw_pkg::DCW_SEC_STANDARD;
        default: general_security_out <= dcw_pkg::DCW_SEC_RESERVED;
      endcase
    end
  end

  // watchdog controls
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      watchdog_enable_out             <= 1'b1;
      low_power_rc_oscillator_run_out <= 1'b1;
      watchdog_window_mode_out        <= 1'b0;
      watchdog_prescale_out           <= `DCW_PRESCALE_HIGH;
      watchdog_postscale_out          <= 16'h8000;
    end else begin
      watchdog_enable_out             <= wd_enable;
      low_power_rc_oscillator_run_out <= wd_enable;
      watchdog_window_mode_out        <= !cfg_reg[4][`DCW_WINDOW_BIT];
      watchdog_prescale_out           <= cfg_reg[4][`DCW_PRESCALE_BIT]
                                         ? `DCW_PRESCALE_HIGH : `DCW_PRESCALE_LOW;
      watchdog_postscale_out          <= 16'h0001 << postscale_sel;
    end
  end

  // power-up timer
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      power_up_timer_enable_out <= 1'b1;
      power_up_timer_ms_out     <= 8'h80;
      power_up_timer_cycles_out <= 24'h000000;
    end else begin
      power_up_timer_enable_out <= (power_up_code != 3'b000);
      power_up_timer_ms_out     <= (power_up_code == 3'b000) ? 8'h00
                                   : 8'h01 << power_up_code;
      power_up_timer_cycles_out <= (power_up_code == 3'b000) ? 24'h000000
                                   : POWER_UP_BASE << (power_up_code - 3'b001);
    end
  end

  dcw_watchdog u_watchdog (
    .clock_in          (clock_in),
    .rst_n_in          (rst_n_in),
    .slow_tick_in      (low_power_rc_tick_in),
    .enable_in         (watchdog_enable_out),
    .prescale_high_in  (cfg_reg[4][`DCW_PRESCALE_BIT]),
    .postscale_sel_in  (postscale_sel),
    .clear_in          (watchdog_clear_instruction_in),
    .sleep_in          (sleep_in),
    .timeout_reset_out (watchdog_reset_out),
    .wake_out          (watchdog_wake_out)
  );

  property p_upper_byte_ones;
    @(posedge clock_in) disable iff (!rst_n_in)
    table_valid_out |-> table_data_out[23:16] == `DCW_UPPER_BYTE;
  endproperty
  a_upper_byte_ones: assert property (p_upper_byte_ones)
    else $error("upper byte of configuration word not all ones");

  property p_readback_watchdog;
    @(posedge clock_in) disable iff (!rst_n_in)
    table_read_in && table_addr_in == `DCW_ADDR_WATCHDOG
      |=> table_valid_out && table_data_out == {`DCW_UPPER_BYTE, $past(cfg_reg[4])};
  endproperty
  a_readback_watchdog: assert property (p_readback_watchdog)
    else $error("watchdog word readback mismatch");

  property p_boot_write_protect;
    @(posedge clock_in) disable iff (!rst_n_in)
    prog_write_in && !chip_erase_in && prog_addr_in == `DCW_ADDR_BOOT
      ##1 !prog_write_in && !chip_erase_in
      |=> boot_write_enable_out == $past(prog_data_in[0], 2);
  endproperty
  a_boot_write_protect: assert property (p_boot_write_protect)
    else $error("boot write enable does not follow programmed bit");

  property p_no_boot_segment;
    @(posedge clock_in) disable iff (!rst_n_in)
    (boot_size[1:0] == 2'b11 || boot_size[1:0] == 2'b00)
      |=> boot_security_out == dcw_pkg::DCW_SEC_NONE && boot_segment_end_out == 24'h000000;
  endproperty
  a_no_boot_segment: assert property (p_no_boot_segment)
    else $error("boot segment created for empty size code");

  property p_small_high_boot;
    @(posedge clock_in) disable iff (!rst_n_in)
    boot_size == 3'b010
      |=> boot_security_out == dcw_pkg::DCW_SEC_HIGH
          && boot_segment_end_out == `DCW_BOOT_END_SMALL;
  endproperty
  a_small_high_boot: assert property (p_small_high_boot)
    else $error("small high-security boot segment wrong");

  property p_forced_watchdog;
    @(posedge clock_in) disable iff (!rst_n_in)
    wd_config_enable |=> watchdog_enable_out && low_power_rc_oscillator_run_out;
  endproperty
  a_forced_watchdog: assert property (p_forced_watchdog)
    else $error("forced watchdog not enabled");

  property p_erase_enables_watchdog;
    @(posedge clock_in) disable iff (!rst_n_in)
    chip_erase_in ##1 !prog_write_in
      |=> watchdog_enable_out && low_power_rc_oscillator_run_out;
  endproperty
  a_erase_enables_watchdog: assert property (p_erase_enables_watchdog)
    else $error("watchdog not enabled after erase");

  property p_prescale_ratio;
    @(posedge clock_in) disable iff (!rst_n_in)
    !cfg_reg[4][`DCW_PRESCALE_BIT] |=> watchdog_prescale_out == `DCW_PRESCALE_LOW;
  endproperty
  a_prescale_ratio: assert property (p_prescale_ratio)
    else $error("prescale ratio wrong");

  property p_postscale_top;
    @(posedge clock_in) disable iff (!rst_n_in)
    postscale_sel == 4'hE |=> watchdog_postscale_out == 16'h4000;
  endproperty
  a_postscale_top: assert property (p_postscale_top)
    else $error("postscale 1110 not 16384");

  property p_power_up_off;
    @(posedge clock_in) disable iff (!rst_n_in)
    power_up_code == 3'b000 |=> !power_up_timer_enable_out && power_up_timer_ms_out == 8'h00;
  endproperty
  a_power_up_off: assert property (p_power_up_off)
    else $error("power-up timer not disabled for code 000");
endmodule // dcw_config_decoder
`default_nettype wire

//--- hdl/dcw_defines.svh
`ifndef DCW_DEFINES_SVH
`define DCW_DEFINES_SVH

// configuration word addresses
`define DCW_ADDR_BOOT      24'hF80000
`define DCW_ADDR_GENERAL   24'hF80004
`define DCW_ADDR_OSC_SEL   24'hF80006
`define DCW_ADDR_OSC       24'hF80008
`define DCW_ADDR_WATCHDOG  24'hF8000A
`define DCW_ADDR_POWER_ON  24'hF8000C
`define DCW_WORD_COUNT     6

// assigned-bit masks, unassigned bits are forced to one
`define DCW_MASK_BOOT      16'h000F
`define DCW_MASK_GENERAL   16'h0007
`define DCW_MASK_OSC_SEL   16'hFFFF
`define DCW_MASK_OSC       16'hFFFF
`define DCW_MASK_WATCHDOG  16'h00DF
`define DCW_MASK_POWER_ON  16'h0007

// reset and erased values
`define DCW_ERASED_WORD    16'hFFFF
`define DCW_UPPER_BYTE     8'hFF
`define DCW_UNMAPPED_READ  24'hFFFFFF

// field positions
`define DCW_BOOT_WP_BIT    0
`define DCW_BOOT_SIZE_LSB  1
`define DCW_GEN_WP_BIT     0
`define DCW_GEN_PROT_LSB   1
`define DCW_WDTEN_BIT      7
`define DCW_WINDOW_BIT     6
`define DCW_PRESCALE_BIT   4
`define DCW_POSTSCALE_LSB  0
`define DCW_POWER_UP_LSB   0
`define DCW_SOFT_EN_BIT    5

// boot segment end addresses
`define DCW_BOOT_END_SMALL  24'h0003FF
`define DCW_BOOT_END_MEDIUM 24'h000FFF

// timing
`define DCW_CLK_HZ         40000000
`define DCW_POWER_UP_BASE_MS 2
`define DCW_PRESCALE_HIGH  8'h80
`define DCW_PRESCALE_LOW   8'h20

`endif

//--- hdl/dcw_pkg.sv
`default_nettype none
package dcw_pkg;
  typedef enum logic [1:0] {
    DCW_SEC_NONE     = 2'b00,
    DCW_SEC_STANDARD = 2'b01,
    DCW_SEC_HIGH     = 2'b10,
    DCW_SEC_RESERVED = 2'b11
  } dcw_security_t;
endpackage
`default_nettype wire

//--- hdl/dcw_watchdog.sv
`default_nettype none
module dcw_watchdog (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       slow_tick_in,
  input  wire logic       enable_in,
  input  wire logic       prescale_high_in,
  input  wire logic [3:0] postscale_sel_in,
  input  wire logic       clear_in,
  input  wire logic       sleep_in,
  output logic            timeout_reset_out,
  output logic            wake_out
);
  logic [6:0]  pre_count_reg;
  logic [14:0] post_count_reg;
  logic [6:0]  pre_limit;
  logic [15:0] post_span;
  logic [14:0] post_limit;
  logic        overflow;

  assign pre_limit  = prescale_high_in ? 7'h7F : 7'h1F;
  assign post_span  = 16'h0001 << postscale_sel_in;
  assign post_limit = 15'(post_span - 16'h0001);
  assign overflow   = enable_in && !clear_in && slow_tick_in
                      && (pre_count_reg == pre_limit) && (post_count_reg == post_limit);

  // clear instruction and disable both restart the count
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !enable_in || clear_in) begin
      pre_count_reg  <= 7'h00;
      post_count_reg <= 15'h0000;
    end else if (slow_tick_in) begin
      if (pre_count_reg == pre_limit) begin
        pre_count_reg  <= 7'h00;
        post_count_reg <= (post_count_reg == post_limit) ? 15'h0000 : post_count_reg + 15'h0001;
      end else begin
        pre_count_reg <= pre_count_reg + 7'h01;
      end
    end
  end

  // sleep turns overflow into wake instead of reset
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      timeout_reset_out <= 1'b0;
      wake_out          <= 1'b0;
    end else begin
      timeout_reset_out <= overflow && !sleep_in;
      wake_out          <= overflow && sleep_in;
    end
  end

  property p_count_restarts;
    @(posedge clock_in) disable iff (!rst_n_in)
    clear_in |=> (pre_count_reg == 7'h00) && (post_count_reg == 15'h0000);
  endproperty
  a_count_restarts: assert property (p_count_restarts)
    else $error("watchdog count not restarted by clear");

  property p_overflow_reset;
    @(posedge clock_in) disable iff (!rst_n_in)
    overflow && !sleep_in |=> timeout_reset_out && !wake_out;
  endproperty
  a_overflow_reset: assert property (p_overflow_reset)
    else $error("watchdog overflow did not reset");

  property p_sleep_wake;
    @(posedge clock_in) disable iff (!rst_n_in)
    wake_out |-> $past(sleep_in) && !timeout_reset_out;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("watchdog wake outside sleep");

  property p_disabled_silent;
    @(posedge clock_in) disable iff (!rst_n_in)
    !enable_in ##1 !enable_in |-> !timeout_reset_out && !wake_out;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent)
    else $error("disabled watchdog fired");
endmodule // dcw_watchdog
`default_nettype wire

//--- verification/dcw_programmer.sv
`default_nettype none
module dcw_programmer (
  input  wire logic        clock_in,
  output logic             prog_write_out,
  output logic [23:0]      prog_addr_out,
  output logic [23:0]      prog_data_out,
  output logic             chip_erase_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    prog_write_out = 1'b0;
    prog_addr_out  = 24'h000000;
    prog_data_out  = 24'h000000;
    chip_erase_out = 1'b0;
  end
  // upper byte sent as zeros so the forced ones inside are visible
  task automatic write_word(input logic [23:0] addr, input logic [15:0] data);
    @(negedge clock_in);
    prog_write_out = 1'b1;
    prog_addr_out  = addr;
    prog_data_out  = {8'h00, data};
    @(negedge clock_in);
    prog_write_out = 1'b0;
    // released bus shows the inverse, never the last value
    prog_addr_out  = ~addr;
    prog_data_out  = ~prog_data_out;
  endtask
  task automatic erase();
    @(negedge clock_in);
    chip_erase_out = 1'b1;
    @(negedge clock_in);
    chip_erase_out = 1'b0;
  endtask
endmodule // dcw_programmer
`default_nettype wire

//--- verification/dcw_config_decoder_tb.sv
`default_nettype none
module dcw_config_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pw, ce, rd_in, valid, rw, swen, tick, clr, slp, bwe, gwe, wen, osc, win, pwe, wrst, wwake;
  logic [23:0] pa, pd, ra, rdata, bend, pcyc;
  logic [15:0] rwd, post;
  logic [7:0] pre, pms;
  dcw_pkg::dcw_security_t bsec, gsec;
  int mismatches = 0;
  int tests_run = 0;
  int rst_seen = 0;
  int wake_seen = 0;
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (wrst === 1'b1) rst_seen++;
    if (wwake === 1'b1) wake_seen++;
  end
  dcw_programmer prog (.clock_in(clock_in), .prog_write_out(pw), .prog_addr_out(pa),
    .prog_data_out(pd), .chip_erase_out(ce));
  dcw_config_decoder #(.LARGE_PART(1'b1), .POWER_UP_BASE_CYCLES(8)) uut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .prog_write_in(pw), .prog_addr_in(pa),
    .prog_data_in(pd), .chip_erase_in(ce), .table_read_in(rd_in), .table_addr_in(ra),
    .table_data_out(rdata), .table_valid_out(valid), .reset_control_write_in(rw),
    .reset_control_wdata_in(rwd), .watchdog_software_enable_out(swen),
    .low_power_rc_tick_in(tick),
    .watchdog_clear_instruction_in(clr), .sleep_in(slp), .boot_write_enable_out(bwe),
    .boot_security_out(bsec), .boot_segment_end_out(bend), .general_write_enable_out(gwe),
    .general_security_out(gsec), .watchdog_enable_out(wen),
    .low_power_rc_oscillator_run_out(osc), .watchdog_window_mode_out(win),
    .watchdog_prescale_out(pre), .watchdog_postscale_out(post),
    .power_up_timer_enable_out(pwe), .power_up_timer_ms_out(pms),
    .power_up_timer_cycles_out(pcyc), .watchdog_reset_out(wrst), .watchdog_wake_out(wwake));
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // decoded outputs lag the write edge by one edge
  task automatic settle();
    repeat (3) @(negedge clock_in);
  endtask
  task automatic rd(input logic [23:0] a, input logic [23:0] e);
    @(negedge clock_in);
    rd_in = 1'b1;
    ra = a;
    @(negedge clock_in);
    rd_in = 1'b0;
    ra = ~a;
    chk({23'h000000, valid}, 24'h000001, "read valid");
    chk(rdata, e, "read data");
  endtask
  task automatic ctrl_write(input logic [15:0] d);
    @(negedge clock_in);
    rw = 1'b1;
    rwd = d;
    @(negedge clock_in);
    rw = 1'b0;
    settle();
  endtask
  task automatic pulse_ticks(input int n);
    repeat (n) begin
      @(negedge clock_in);
      tick = 1'b1;
      @(negedge clock_in);
      tick = 1'b0;
    end
  endtask
  task automatic wd_clear();
    @(negedge clock_in);
    clr = 1'b1;
    @(negedge clock_in);
    clr = 1'b0;
  endtask
  task automatic s_erased();
    logic [23:0] addrs [6] = '{24'hF80000, 24'hF80004, 24'hF80006, 24'hF80008,
                               24'hF8000A, 24'hF8000C};
    chk({23'h0, wen}, 24'h1, "erased watchdog on");
    chk({16'h0, pre}, 24'h80, "erased prescale");
    chk({8'h0, post}, 24'h8000, "erased postscale");
    chk({16'h0, pms}, 24'h80, "erased timer ms");
    foreach (addrs[i]) rd(addrs[i], 24'hFFFFFF);
    rd(24'hF80002, 24'hFFFFFF);
  endtask
  task automatic s_boot();
    logic [1:0] es;
    logic [23:0] ee;
    for (int c = 0; c < 8; c++) begin
      es = dcw_pkg::DCW_SEC_NONE;
      ee = 24'h000000;
      if (c[1:0] == 2'b10) ee = 24'h0003FF;
      if (c[1:0] == 2'b01) ee = 24'h000FFF;
      if (ee != 24'h000000) es = c[2] ? dcw_pkg::DCW_SEC_STANDARD : dcw_pkg::DCW_SEC_HIGH;
      prog.write_word(24'hF80000, {12'h000, c[2:0], c[0]});
      settle();
      chk({23'h0, bwe}, {23'h0, c[0]}, "boot write enable");
      chk({22'h0, bsec}, {22'h0, es}, "boot security");
      chk(bend, ee, "boot end");
    end
  endtask
  task automatic s_general();
    logic [1:0] es;
    for (int c = 0; c < 4; c++) begin
      es = c[1] ? (c[0] ? dcw_pkg::DCW_SEC_NONE : dcw_pkg::DCW_SEC_STANDARD)
                : dcw_pkg::DCW_SEC_RESERVED;
      prog.write_word(24'hF80004, {13'h0000, c[1:0], ~c[0]});
      settle();
      chk({23'h0, gwe}, {23'h0, ~c[0]}, "general write enable");
      chk({22'h0, gsec}, {22'h0, es}, "general security");
    end
  endtask
  task automatic s_power_up_timer();
    for (int c = 0; c < 8; c++) begin
      prog.write_word(24'hF8000C, {13'h0000, c[2:0]});
      settle();
      chk({23'h0, pwe}, {23'h0, c != 0}, "timer enable");
      chk({16'h0, pms}, c == 0 ? 24'h0 : 24'h1 << c, "timer ms");
      chk(pcyc, c == 0 ? 24'h0 : 24'h8 << (c - 1), "timer cycles");
    end
  endtask
  task automatic s_wd_config();
    prog.write_word(24'hF8000A, 16'h0000);
    settle();
    rd(24'hF8000A, 24'hFFFF20);
    chk({22'h0, win, wen}, 24'h2, "window mode, software off");
    chk({16'h0, pre}, 24'h20, "prescale 32");
    chk({8'h0, post}, 24'h0001, "postscale 1");
    ctrl_write(16'h0020);
    chk({21'h0, swen, wen, osc}, 24'h7, "software on");
    ctrl_write(16'hFFDF);
    chk({21'h0, swen, wen, osc}, 24'h0, "software off");
    prog.write_word(24'hF8000A, 16'h00DE);
    settle();
    rd(24'hF8000A, 24'hFFFFFE);
    chk({22'h0, win, wen}, 24'h1, "forced on, no window");
    chk({8'h0, post}, 24'h4000, "postscale 16384");
    ctrl_write(16'h0020);
    ctrl_write(16'h0000);
    chk({21'h0, swen, wen, osc}, 24'h7, "clear ignored");
  endtask
  task automatic s_overflow();
    prog.write_word(24'hF8000A, 16'h00C0);
    settle();
    wd_clear();
    rst_seen = 0;
    pulse_ticks(20);
    wd_clear();
    pulse_ticks(31);
    settle();
    chk(rst_seen, 24'h0, "clear restarts count");
    pulse_ticks(1);
    settle();
    chk(rst_seen, 24'h1, "overflow reset");
    slp = 1'b1;
    wd_clear();
    wake_seen = 0;
    pulse_ticks(32);
    settle();
    chk({wake_seen[11:0], rst_seen[11:0]}, 24'h001001, "sleep wake");
    slp = 1'b0;
    prog.erase();
    settle();
    rd(24'hF8000A, 24'hFFFFFF);
    chk({23'h0, wen}, 24'h1, "erase enables watchdog");
  endtask
  // mid-run reset drops programmed words and the software enable
  task automatic s_reset();
    prog.write_word(24'hF80004, 16'h0000);
    prog.write_word(24'hF80006, 16'h1234);
    prog.write_word(24'hF80008, 16'h00C3);
    settle();
    rd(24'hF80004, 24'hFFFFF8);
    rd(24'hF80006, 24'hFF1234);
    rd(24'hF80008, 24'hFF00C3);
    chk({22'h0, gwe, swen}, 24'h1, "before reset");
    @(negedge clock_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk({22'h0, valid, swen}, 24'h0, "reset clears valid and enable");
    chk(rdata, 24'hFFFFFF, "reset read data");
    rst_n_in = 1'b1;
    @(negedge clock_in);
    chk({22'h0, gwe, wen}, 24'h3, "reset reloads erased words");
    rd(24'hF80004, 24'hFFFFFF);
  endtask
  initial begin
    {rd_in, rw, tick, clr, slp} = 5'h00;
    ra = 24'h000000;
    rwd = 16'h0000;
    repeat (5) @(negedge clock_in);
    rst_n_in = 1'b1;
    @(negedge clock_in);
    s_erased();
    s_boot();
    s_general();
    s_power_up_timer();
    s_wd_config();
    s_overflow();
    s_reset();
    report_and_stop();
  end
endmodule // dcw_config_decoder_tb
`default_nettype wire
